// >>> hw/asu_uart.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module asu_uart (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    input  wire logic       timer_tick,
    input  wire logic       rxd,
    output logic            txd,
    output logic            transmit_interrupt,
    output logic            receive_interrupt
);
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} asu_state_t;

    asu_pkg::asu_bus_t  bus;
    asu_pkg::asu_ctrl_t ctrl_ff;
    logic               rx_two_stop_ff;
    logic [7:0]         rdata_ff, nxt_rdata;
    logic               txd_ff, tint_ff, rint_ff;
    logic               tx_empty_ff, tx_end_ff, rx_full_ff, par_err_ff, frm_err_ff, ovr_ff;
    logic               ovr_seen_ff;
    logic               sr_read_ff;
    logic [7:0]         tx_hold_ff, rx_buf_ff;
    logic               tx_pend_ff;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    wire wr_c1  = bus.wr && bus.addr == asu_pkg::ADDR_CTRL1;
    wire wr_c2  = bus.wr && bus.addr == asu_pkg::ADDR_CTRL2;
    wire wr_buf = bus.wr && bus.addr == asu_pkg::ADDR_BUF;
    wire rd_sr  = bus.rd && bus.addr == asu_pkg::ADDR_CTRL1;
    wire rd_buf = bus.rd && bus.addr == asu_pkg::ADDR_BUF;
    wire [7:0] status = {par_err_ff, frm_err_ff, ovr_ff, rx_full_ff, tx_end_ff, tx_empty_ff, 2'b00};

    // status shares its address with control one: writes hit control, reads see status
    assign nxt_rdata = rd_sr ? status :
                       rd_buf ? rx_buf_ff :
                       (bus.rd && bus.addr == asu_pkg::ADDR_CTRL2) ? {7'h00, rx_two_stop_ff} : 8'h00;

    // ---------------- bit clock ----------------
    logic [11:0] div_cnt_ff;
    wire  [11:0] div_top = (ctrl_ff.sel == asu_pkg::SEL_FC96) ? 12'(asu_pkg::DIV_FC96 - 1) :
                           12'((asu_pkg::DIV_BASE << ctrl_ff.sel[2:0]) - 1);
    wire  div_wrap = div_cnt_ff >= div_top;
    // timer source supplies the bit clock directly; 16 of them make one baud
    wire  bclk = (ctrl_ff.sel == asu_pkg::SEL_TIMER) ? timer_tick : div_wrap;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) div_cnt_ff <= 12'h000;
        else       div_cnt_ff <= div_wrap ? 12'h000 : div_cnt_ff + 12'h001;
    end

    // ---------------- transmitter ----------------
    asu_state_t tx_st_ff;
    logic [3:0] tx_tick_ff, tx_cnt_ff;
    logic [7:0] tx_sh_ff;
    logic       tx_par_ff;
    wire tx_bit_end = bclk && tx_tick_ff == asu_pkg::TICKS_PER_BIT;
    wire tx_start   = tx_st_ff == ST_IDLE && tx_pend_ff && ctrl_ff.tx_on && bclk;
    wire tx_last_stop = tx_cnt_ff == (ctrl_ff.tx_two_stop ? 4'h1 : 4'h0);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_st_ff   <= ST_IDLE;
            tx_tick_ff <= 4'h0;
            tx_cnt_ff  <= 4'h0;
            tx_sh_ff   <= 8'h00;
            tx_par_ff  <= 1'b0;
            txd_ff     <= 1'b1;
        end else begin
            if (bclk) tx_tick_ff <= tx_st_ff == ST_IDLE ? 4'h0 : tx_tick_ff + 4'h1;
            unique case (tx_st_ff)
                ST_IDLE: begin
                    txd_ff <= 1'b1;
                    if (tx_start) begin
                        tx_st_ff  <= ST_START;
                        tx_sh_ff  <= tx_hold_ff;
                        tx_par_ff <= ^tx_hold_ff ^ ~ctrl_ff.even;
                        txd_ff    <= 1'b0;
                    end
                end
                ST_START: if (tx_bit_end) begin
                    tx_st_ff  <= ST_DATA;
                    tx_cnt_ff <= 4'h0;
                    txd_ff    <= tx_sh_ff[0];
                end
                ST_DATA: if (tx_bit_end) begin
                    tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
                    tx_cnt_ff <= tx_cnt_ff + 4'h1;
                    if (tx_cnt_ff == asu_pkg::DATA_BITS - 4'h1) begin
                        tx_cnt_ff <= 4'h0;
                        tx_st_ff  <= ctrl_ff.par_en ? ST_PAR : ST_STOP;
                        txd_ff    <= ctrl_ff.par_en ? tx_par_ff : 1'b1;
                    end else begin
                        txd_ff <= tx_sh_ff[1];
                    end
                end
                ST_PAR: if (tx_bit_end) begin
                    tx_st_ff <= ST_STOP;
                    txd_ff   <= 1'b1;
                end
                ST_STOP: if (tx_bit_end) begin
                    tx_cnt_ff <= tx_cnt_ff + 4'h1;
                    if (tx_last_stop) begin
                        tx_st_ff  <= ST_IDLE;
                        tx_cnt_ff <= 4'h0;
                    end
                end
                default: tx_st_ff <= ST_IDLE;
            endcase
        end
    end
    wire tx_done = tx_st_ff == ST_STOP && tx_bit_end && tx_last_stop;

    // ---------------- receiver ----------------
    asu_state_t rx_st_ff;
    logic [3:0] rx_tick_ff, rx_cnt_ff;
    logic [7:0] rx_sh_ff;
    logic [1:0] votes_ff;
    logic       rx_par_bad_ff, rx_frm_bad_ff, rx_en_ff;
    wire rx_sample = bclk && rx_tick_ff >= asu_pkg::TICK_S0 && rx_tick_ff <= asu_pkg::TICK_S2;
    wire rx_bit_end = bclk && rx_tick_ff == asu_pkg::TICKS_PER_BIT;
    wire [1:0] votes_now = votes_ff + {1'b0, rx_sample & rxd};
    wire rx_bit = votes_ff >= 2'd2;
    wire rx_last_stop = rx_cnt_ff == (rx_two_stop_ff ? 4'h1 : 4'h0);
    wire rx_done = rx_st_ff == ST_STOP && rx_bit_end && rx_last_stop;
    wire rx_frm_bad_now = rx_frm_bad_ff | ~rx_bit;
    wire rx_deliver = rx_done && !rx_full_ff;
    wire rx_overrun = rx_done && rx_full_ff;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_st_ff   <= ST_IDLE;
            rx_tick_ff <= 4'h0;
            rx_cnt_ff  <= 4'h0;
            rx_sh_ff      <= 8'h00;
            votes_ff      <= 2'd0;
            rx_par_bad_ff <= 1'b0;
            rx_frm_bad_ff <= 1'b0;
            rx_en_ff      <= 1'b0;
        end else begin
            if (bclk) rx_tick_ff <= rx_st_ff == ST_IDLE ? 4'h0 : rx_tick_ff + 4'h1;
            votes_ff <= rx_bit_end ? 2'd0 : votes_now;
            // enable is latched only between frames, so a clear waits for frame end
            if (rx_st_ff == ST_IDLE) rx_en_ff <= ctrl_ff.rx_on;
            unique case (rx_st_ff)
                ST_IDLE: if (bclk && !rxd && rx_en_ff && ctrl_ff.rx_on && !ovr_ff) begin
                    rx_st_ff      <= ST_START;
                    rx_tick_ff    <= 4'h1;
                    votes_ff      <= 2'd0;
                    rx_frm_bad_ff <= 1'b0;
                    rx_par_bad_ff <= 1'b0;
                end
                ST_START: if (rx_bit_end) begin
                    // a start bit voted high was noise
                    rx_st_ff  <= rx_bit ? ST_IDLE : ST_DATA;
                    rx_cnt_ff <= 4'h0;
                end
                ST_DATA: if (rx_bit_end) begin
                    rx_sh_ff  <= {rx_bit, rx_sh_ff[7:1]};
                    rx_cnt_ff <= rx_cnt_ff + 4'h1;
                    if (rx_cnt_ff == asu_pkg::DATA_BITS - 4'h1) begin
                        rx_cnt_ff <= 4'h0;
                        rx_st_ff  <= ctrl_ff.par_en ? ST_PAR : ST_STOP;
                    end
                end
                ST_PAR: if (rx_bit_end) begin
                    rx_par_bad_ff <= (^rx_sh_ff ^ ~ctrl_ff.even) != rx_bit;
                    rx_st_ff   <= ST_STOP;
                end
                ST_STOP: if (rx_bit_end) begin
                    rx_frm_bad_ff <= rx_frm_bad_now;
                    rx_cnt_ff  <= rx_cnt_ff + 4'h1;
                    if (rx_last_stop) begin
                        rx_st_ff  <= ST_IDLE;
                        rx_cnt_ff <= 4'h0;
                    end
                end
                default: rx_st_ff <= ST_IDLE;
            endcase
        end
    end

    // ---------------- registers and flags ----------------
    wire buf_clear = rd_buf && sr_read_ff;
    wire tx_accept = wr_buf && sr_read_ff;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff        <= asu_pkg::CTRL1_RESET;
            rx_two_stop_ff <= asu_pkg::CTRL2_RESET[asu_pkg::STOPR_BIT];
            rdata_ff       <= 8'h00;
            sr_read_ff     <= 1'b0;
            tx_hold_ff     <= 8'h00;
            tx_pend_ff     <= 1'b0;
            rx_buf_ff      <= 8'h00;
            tx_empty_ff    <= 1'b1;
            tx_end_ff      <= 1'b1;
            rx_full_ff     <= 1'b0;
            par_err_ff     <= 1'b0;
            frm_err_ff     <= 1'b0;
            ovr_ff         <= 1'b0;
            ovr_seen_ff    <= 1'b0;
            tint_ff        <= 1'b0;
            rint_ff        <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            if (wr_c1) ctrl_ff <= asu_pkg::asu_ctrl_t'(bus.wdata);
            if (wr_c2) rx_two_stop_ff <= bus.wdata[asu_pkg::STOPR_BIT];
            if (rd_sr) sr_read_ff <= 1'b1;
            else if (rd_buf || wr_buf) sr_read_ff <= 1'b0;
            if (tx_accept) begin
                tx_hold_ff  <= bus.wdata;
                tx_pend_ff  <= 1'b1;
                tx_empty_ff <= 1'b0;
            end
            tint_ff <= tx_start;
            if (tx_start) begin
                tx_pend_ff  <= 1'b0;
                tx_empty_ff <= 1'b1;
                tx_end_ff   <= 1'b0;
            end
            if (tx_done && !tx_pend_ff) tx_end_ff <= 1'b1;
            rint_ff <= rx_deliver;
            // overrun as software saw it; only a seen overrun may be cleared by the buffer read
            if (rd_sr) ovr_seen_ff <= ovr_ff;
            // hardware sets win over the read-clear in the same cycle
            if (buf_clear) begin
                rx_full_ff <= 1'b0;
                par_err_ff <= 1'b0;
                frm_err_ff <= 1'b0;
                if (ovr_seen_ff) ovr_ff <= 1'b0;
            end
            if (rx_deliver) begin
                rx_buf_ff  <= rx_sh_ff;
                rx_full_ff <= 1'b1;
                par_err_ff <= rx_par_bad_ff;
                frm_err_ff <= rx_frm_bad_now;
            end
            // overrun raised after the status read is not cleared by this buffer read
            if (rx_overrun) ovr_ff <= 1'b1;
        end
    end

    assign rdata              = rdata_ff;
    assign txd                = txd_ff;
    assign transmit_interrupt = tint_ff;
    assign receive_interrupt  = rint_ff;
endmodule

// >>> hw/asu_pkg.sv
// How it works
// - frame is one low start bit, data, optional parity, then high stop bits
// - timer select: bit clock is timer tick, baud is that divided by 16
// - code 000 gives fc/13 bit clock; each higher code halves it up to 101
// - idle receiver keeps sampling rx pin and treats low as possible start
// - every bit sampled at sub-bit ticks 7, 8, 9; majority decides
// - transmitter sends one or two stop bits per transmit stop length
// - parity enable adds parity bit; parity type picks odd or even
// - buffer write after status read clears empty flag and loads byte for shifting out
// - when transmission starts, empty flag sets and transmit interrupt pulses
// - tx pin high while disabled and until a byte is written
// - after stop bits, data loads receive buffer, sets full flag, interrupt
// - frame arriving while buffer full sets overrun and drops data
// - receiver stays disabled while overrun flag is set
// - clearing receive enable takes effect only after current frame
// - parity error flag sets when computed parity disagrees with received
// - framing error flag sets when a stop bit samples as zero
// - error and full flags clear on buffer read after status read
// - overrun set between status read and buffer read stays set
// - end flag sets when done with buffer empty, clears on new start
// - bit clock and parity settings shared by transmitter and receiver
// - receiver stop length has its own independent control
package asu_pkg;
    localparam logic [7:0] ADDR_CTRL1    = 8'h20;
    localparam logic [7:0] ADDR_CTRL2    = 8'h21;
    localparam logic [7:0] ADDR_BUF      = 8'h22;
    localparam logic [7:0] CTRL1_RESET   = 8'h00;
    localparam logic [7:0] CTRL2_RESET   = 8'h00;
    localparam int         TX_ON_BIT     = 7;
    localparam int         RX_ON_BIT     = 6;
    localparam int         TX_STOP2_BIT  = 5;
    localparam int         EVEN_BIT      = 4;
    localparam int         PAR_EN_BIT    = 3;
    localparam int         STOPR_BIT     = 0;
    localparam logic [2:0] SEL_TIMER     = 3'h6;
    localparam logic [2:0] SEL_FC96      = 3'h7;
    // bit-clock dividers in core cycles; 000 is fc/13
    localparam int         DIV_BASE      = 13;
    localparam int         DIV_FC96      = 96;
    localparam logic [3:0] TICKS_PER_BIT = 4'hf;
    localparam logic [3:0] TICK_S0       = 4'h7;
    localparam logic [3:0] TICK_S2       = 4'h9;
    localparam logic [3:0] DATA_BITS     = 4'h8;

    typedef struct packed {
        logic       tx_on;
        logic       rx_on;
        logic       tx_two_stop;
        logic       even;
        logic       par_en;
        logic [2:0] sel;
    } asu_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } asu_bus_t;
endpackage

// >>> verif/asu_uart_sva.sv
`timescale 1ns/1ps
module asu_uart_chk (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       timer_tick,
    input wire logic       rxd,
    input wire logic       txd,
    input wire logic       transmit_interrupt,
    input wire logic       receive_interrupt
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic sent_ff;
    logic unmapped;
    assign unmapped = addr < asu_pkg::ADDR_CTRL1 || addr > asu_pkg::ADDR_BUF;
    // remembers whether any frame was ever launched since reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sent_ff <= 1'b0;
        end else if (transmit_interrupt) begin
            sent_ff <= 1'b1;
        end
    end
    property p_idle;
        !txd |-> sent_ff || transmit_interrupt;
    endproperty
    property p_tpulse;
        transmit_interrupt |=> !transmit_interrupt [*8];
    endproperty
    property p_start;
        transmit_interrupt |-> ##[0:2] !txd;
    endproperty
    property p_startlen;
        $fell(txd) |-> !txd [*8];
    endproperty
    property p_rpulse;
        receive_interrupt |=> !receive_interrupt [*8];
    endproperty
    property p_rquiet;
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    property p_unmapped;
        rd && unmapped |=> rdata == 8'h00;
    endproperty
    property p_stop2;
        wr && addr == asu_pkg::ADDR_CTRL2 ##2 rd && addr == asu_pkg::ADDR_CTRL2 |=> rdata[0] == $past(wdata[0], 3);
    endproperty
    a_idle: assert property (p_idle) else $error("txd low before any launch");
    a_tpulse: assert property (p_tpulse) else $error("transmit pulse too long");
    a_start: assert property (p_start) else $error("no start bit after launch");
    a_startlen: assert property (p_startlen) else $error("start bit too short");
    a_rpulse: assert property (p_rpulse) else $error("receive pulse too long");
    a_rquiet: assert property (p_rquiet) else $error("read data without read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_stop2: assert property (p_stop2) else $error("stop length readback wrong");
    c_tx: cover property (transmit_interrupt);
    c_rx: cover property (receive_interrupt);
    c_unm: cover property (rd && unmapped);
endmodule

bind asu_uart asu_uart_chk i_asu_uart_chk (
    .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .timer_tick(timer_tick), .rxd(rxd), .txd(txd), .transmit_interrupt(transmit_interrupt),
    .receive_interrupt(receive_interrupt)
);

// >>> verif/asu_remote.sv
`timescale 1ns/1ps
module asu_remote (
    input  wire logic sys_clk,
    input  wire logic txd,
    output logic      rxd
);
    int         bit_cyc = 64;
    int         cyc     = 0;
    int         t_last  = 0;
    int         low_len = 0;
    int         n_rx    = 0;
    logic [8:0] q_frame[$];
    int         q_gap[$];
    logic [8:0] fr;
    initial rxd = 1'b1;
    // blocking so the count is settled before the design's outputs move
    always @(posedge sys_clk) cyc++;
    always @(posedge txd) low_len = cyc - t_last;
    // mid-bit sampling, lsb first: eight data then parity or stop
    always @(negedge txd) begin
        q_gap.push_back(cyc - t_last);
        t_last = cyc;
        repeat (bit_cyc / 2) @(posedge sys_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (bit_cyc) @(posedge sys_clk);
            fr[i] = txd;
        end
        q_frame.push_back(fr);
        n_rx++;
    end
    // line idles high between frames
    task automatic send(input logic [7:0] d, input logic p, input logic s1, input logic s2);
        logic [11:0] bits;
        bits = {s2, s1, p, d, 1'b0};
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            rxd <= bits[i];
            repeat (bit_cyc - 1) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        rxd <= 1'b1;
    endtask
endmodule

// >>> verif/test_async_serial_uart.sv
`timescale 1ns/1ps
module test_async_serial_uart;
    logic        sys_clk    = 1'b0;
    logic        rstn       = 1'b0;
    logic [7:0]  addr       = 8'h00;
    logic [7:0]  wdata      = 8'h00;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic        timer_tick = 1'b0;
    logic [1:0]  tdiv       = 2'h0;
    logic [7:0]  rdata;
    logic        rxd;
    logic        txd;
    logic        transmit_interrupt;
    logic        receive_interrupt;
    logic [8:0]  fr;
    int          n_fail     = 0;
    int          n_compared = 0;
    int          n_cyc      = 0;
    // data, status, then {rx two stops, bad parity, stop1, stop2}
    logic [31:0] rows [5]   = '{32'h5A1C_0003, 32'hC39C_0007, 32'h7E5C_0001, 32'h815C_000A, 32'h241C_000B};

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        tdiv <= tdiv + 2'h1;
        timer_tick <= tdiv == 2'h3;
        n_cyc <= n_cyc + 1;
        if (n_cyc == 60000) begin
            n_fail++;
            complete_run();
        end
    end

    asu_uart i_asu_uart (
        .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .timer_tick(timer_tick), .rxd(rxd), .txd(txd), .transmit_interrupt(transmit_interrupt),
        .receive_interrupt(receive_interrupt)
    );
    asu_remote i_asu_remote (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk($sformatf("reg %0h", a), rdata, exp);
    endtask
    task automatic wait_irq(input logic rx);
        int n;
        n = 0;
        while ((rx ? receive_interrupt : transmit_interrupt) !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("interrupt wait", n < 5000, 1);
    endtask
    task automatic wait_rx(input int cnt);
        int n;
        n = 0;
        while (i_asu_remote.n_rx < cnt && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("frame wait", n < 20000, 1);
    endtask
    task automatic complete_run();
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        rd_chk(asu_pkg::ADDR_CTRL1, 8'h0C);
        rd_chk(asu_pkg::ADDR_CTRL2, 8'h00);
        rd_chk(8'h23, 8'h00);
        // timer ticks every 4 cycles, so one bit is 64 cycles
        for (int k = 0; k < 2; k++) begin
            wr_reg(asu_pkg::ADDR_CTRL1, {2'b11, k[0], ~k[0], 4'b1110});
            rd_chk(asu_pkg::ADDR_CTRL1, 8'h0C);
            wr_reg(asu_pkg::ADDR_BUF, 8'hA5);
            wait_irq(1'b0);
            rd_chk(asu_pkg::ADDR_CTRL1, 8'h04);
            wr_reg(asu_pkg::ADDR_BUF, 8'h3C);
            wait_irq(1'b0);
            wait_rx(2 * k + 2);
            repeat (250) @(posedge sys_clk);
            rd_chk(asu_pkg::ADDR_CTRL1, 8'h0C);
            fr = i_asu_remote.q_frame.pop_front();
            chk("tx frame", fr, {^8'hA5 ^ k[0], 8'hA5});
            fr = i_asu_remote.q_frame.pop_front();
            chk("tx frame", fr, {^8'h3C ^ k[0], 8'h3C});
            void'(i_asu_remote.q_gap.pop_front());
            chk("frame bits", (i_asu_remote.q_gap.pop_front() + 32) / 64, 11 + k);
        end
        wr_reg(asu_pkg::ADDR_CTRL1, 8'hDE);
        foreach (rows[i]) begin
            wr_reg(asu_pkg::ADDR_CTRL2, {7'h00, rows[i][3]});
            rd_chk(asu_pkg::ADDR_CTRL2, {7'h00, rows[i][3]});
            fork
                i_asu_remote.send(rows[i][31:24], ^rows[i][31:24] ^ rows[i][2], rows[i][1], rows[i][0]);
                wait_irq(1'b1);
            join
            rd_chk(asu_pkg::ADDR_CTRL1, rows[i][23:16]);
            rd_chk(asu_pkg::ADDR_BUF, rows[i][31:24]);
            rd_chk(asu_pkg::ADDR_CTRL1, 8'h0C);
        end
        i_asu_remote.send(8'h11, ^8'h11, 1'b1, 1'b1);
        i_asu_remote.send(8'h22, ^8'h22, 1'b1, 1'b1);
        rd_chk(asu_pkg::ADDR_CTRL1, 8'h3C);
        rd_chk(asu_pkg::ADDR_BUF, 8'h11);
        rd_chk(asu_pkg::ADDR_CTRL1, 8'h0C);
        // the buffer read uses up the status read, so the next write is refused
        rd_chk(asu_pkg::ADDR_BUF, 8'h11);
        wr_reg(asu_pkg::ADDR_BUF, 8'h55);
        rd_chk(asu_pkg::ADDR_CTRL1, 8'h0C);
        // an overrun that arrives after the status read survives the buffer read
        i_asu_remote.send(8'h66, ^8'h66, 1'b1, 1'b1);
        rd_chk(asu_pkg::ADDR_CTRL1, 8'h1C);
        i_asu_remote.send(8'h77, ^8'h77, 1'b1, 1'b1);
        rd_chk(asu_pkg::ADDR_BUF, 8'h66);
        rd_chk(asu_pkg::ADDR_CTRL1, 8'h2C);
        rd_chk(asu_pkg::ADDR_BUF, 8'h66);
        rd_chk(asu_pkg::ADDR_CTRL1, 8'h0C);
        // codes 000 and 001 of the core divider, then the fixed fc/96 code
        for (int s = 0; s < 3; s++) begin
            i_asu_remote.bit_cyc = (s == 2) ? 96 * 16 : 208 << s;
            wr_reg(asu_pkg::ADDR_CTRL1, {5'b10000, (s == 2) ? 3'h7 : s[2:0]});
            rd_chk(asu_pkg::ADDR_CTRL1, 8'h0C);
            wr_reg(asu_pkg::ADDR_BUF, 8'h00);
            wait_rx(5 + s);
            chk("low time", i_asu_remote.low_len, 9 * i_asu_remote.bit_cyc);
            // let the stop bit end before the divider code changes
            repeat (i_asu_remote.bit_cyc) @(posedge sys_clk);
        end
        complete_run();
    end
endmodule
